// >>> design/ssom_pkg.sv
// package: constants, register map and types of the servo status output mapper
package ssom_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL      = 8'h00; // mode, ready, brake
  localparam logic [7:0] OFF_SOFT_WORD = 8'h04;
  localparam logic [7:0] OFF_ZERO_THR  = 8'h08;
  localparam logic [7:0] OFF_TGT_THR   = 8'h0c;
  localparam logic [7:0] OFF_POS_THR   = 8'h10;
  localparam logic [7:0] OFF_SERR_THR  = 8'h14;
  localparam logic [7:0] OFF_ASSIGN0   = 8'h18; // channels 0..2
  localparam logic [7:0] OFF_ASSIGN1   = 8'h1c; // channels 3..5
  localparam logic [7:0] OFF_FLAGS     = 8'h20; // read only
  localparam logic [7:0] OFF_OUTS      = 8'h24; // read only

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_MODE_LSB  = 0;  // 3 bits
  localparam int CTRL_READY_BIT = 4;
  localparam int CTRL_BRAKE_BIT = 5;
  localparam int ASSIGN_FIELD_W = 10; // 8-bit function, 2-bit mode mask
  localparam int CH_PER_WORD    = 3;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
  localparam logic [31:0] RST_ZERO   = 32'h0000_000a;
  localparam logic [31:0] RST_TGT    = 32'h0000_0bb8;
  localparam logic [31:0] RST_POS    = 32'h0000_0064;
  localparam logic [31:0] RST_SERR   = 32'h0000_000a;
  localparam logic [31:0] RST_ASSIGN = 32'h0000_0000; // all channels unassigned

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ------------------------------------------------------------
  // control modes and output functions
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_PULSE = 3'b000, // pulse_train_position_mode
    MODE_S   = 3'b001,
    MODE_SZ  = 3'b010,
    MODE_T   = 3'b011,
    MODE_TZ  = 3'b100
  } ssom_mode_type;

  localparam logic [7:0] FN_NONE   = 8'h00;
  localparam logic [7:0] FN_READY  = 8'h01;
  localparam logic [7:0] FN_ZERO   = 8'h02;
  localparam logic [7:0] FN_TGT    = 8'h03;
  localparam logic [7:0] FN_POS    = 8'h04;
  localparam logic [7:0] FN_TORQUE = 8'h05;
  localparam logic [7:0] FN_ALARM  = 8'h07;
  localparam logic [7:0] FN_BRAKE  = 8'h08;
  localparam logic [7:0] FN_OVL    = 8'h10;
  localparam logic [7:0] FN_WARN   = 8'h11;
  localparam logic [7:0] FN_SCMP   = 8'h12;
  localparam logic [7:0] FN_SOFT0  = 8'h30; // 0x30..0x3f soft bits

  typedef struct packed {
    logic alarm_any;    // fault other than the five warning causes
    logic rev_limit;
    logic fwd_limit;
    logic emerg_stop;
    logic comm_err;
    logic undervolt;
    logic torque_lim;
    logic overload;
  } ssom_cond_type;

  typedef struct packed {
    logic speed_compare_flag;
    logic warning_flag;
    logic overload_warning_flag;
    logic brake_control_output;
    logic alarm_flag;
    logic torque_limit_flag;
    logic position_reached_flag;
    logic target_speed_flag;
    logic zero_speed_flag;
    logic servo_ready_flag;
  } ssom_flags_type;

endpackage

// >>> design/ssom_mapper.sv
// servo status output mapper: flag derivation, channel mapping, AXI4-Lite registers
`timescale 1ns/1ps

// Behaviour
// - ready flag only when ready and fault free
// - zero-speed flag when speed at/below threshold
// - target-speed flag when reached, not pulse-train
// - torque-limit flag when limit reached
// - alarm on fault; warning first on the five causes
// - warning on five listed fault causes
// - brake output assignable in every mode
// - overload flag when overload level reached
// - speed-compare flag in speed modes, small error
// - soft function n drives bit n
// - fixed channels, any function per channel
// - sixteen soft output bits
// - unassigned functions never reach outputs
module ssom_mapper #(
  parameter int SPD_W = 16,
  parameter int N_CH  = 6
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [SPD_W-1:0]     motor_speed,
  input  wire logic [SPD_W-1:0]     speed_error,
  input  wire logic [SPD_W-1:0]     position_error,
  input  wire ssom_pkg::ssom_cond_type cond,
  output logic      [N_CH-1:0]      out_channel,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic below(input logic [SPD_W-1:0] v, input logic [31:0] thr);
    return 32'(v) <= thr;
  endfunction

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] soft_q, soft_d;
  logic [31:0] zthr_q, zthr_d;
  logic [31:0] tthr_q, tthr_d;
  logic [31:0] pthr_q, pthr_d;
  logic [31:0] sthr_q, sthr_d;
  logic [31:0] asg0_q, asg0_d;
  logic [31:0] asg1_q, asg1_d;

  logic        aw_hold_q, aw_hold_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic        w_hold_q,  w_hold_d;
  logic [31:0] w_data_q,  w_data_d;
  logic [3:0]  w_strb_q,  w_strb_d;
  logic        bvalid_q,  bvalid_d;
  logic [1:0]  bresp_q,   bresp_d;
  logic        rvalid_q,  rvalid_d;
  logic [31:0] rdata_q,   rdata_d;
  logic [1:0]  rresp_q,   rresp_d;

  ssom_pkg::ssom_flags_type flags_q, flags_d;
  logic warn_seen_q, warn_seen_d;
  logic [N_CH-1:0] out_q, out_d;

  ssom_pkg::ssom_mode_type mode;
  assign mode = ssom_pkg::ssom_mode_type'(ctrl_q[ssom_pkg::CTRL_MODE_LSB +: 3]);

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  logic do_write;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic        wr_ok;
  logic        rd_ok;
  logic [31:0] rd_val;

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_comb begin
    aw_hold_d = aw_hold_q;
    aw_addr_d = aw_addr_q;
    w_hold_d  = w_hold_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    do_write = aw_hold_d && w_hold_d && !bvalid_q;
    wa = aw_addr_d;
    wd = w_data_d;
    ws = w_strb_d;
    if (do_write) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_ok ? ssom_pkg::RESP_OKAY : ssom_pkg::RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_comb begin
    wr_ok = 1'b1;
    case (wa)
      ssom_pkg::OFF_CTRL, ssom_pkg::OFF_SOFT_WORD, ssom_pkg::OFF_ZERO_THR,
      ssom_pkg::OFF_TGT_THR, ssom_pkg::OFF_POS_THR, ssom_pkg::OFF_SERR_THR,
      ssom_pkg::OFF_ASSIGN0, ssom_pkg::OFF_ASSIGN1: wr_ok = 1'b1;
      default: wr_ok = 1'b0; // status words and holes refuse writes
    endcase
  end

  always_comb begin
    ctrl_d = ctrl_q;
    soft_d = soft_q;
    zthr_d = zthr_q;
    tthr_d = tthr_q;
    pthr_d = pthr_q;
    sthr_d = sthr_q;
    asg0_d = asg0_q;
    asg1_d = asg1_q;
    if (do_write) begin
      case (wa)
        ssom_pkg::OFF_CTRL:      ctrl_d = merge(ctrl_q, wd, ws) & 32'h0000_0037;
        ssom_pkg::OFF_SOFT_WORD: soft_d = merge(soft_q, wd, ws) & 32'h0000_ffff;
        ssom_pkg::OFF_ZERO_THR:  zthr_d = merge(zthr_q, wd, ws);
        ssom_pkg::OFF_TGT_THR:   tthr_d = merge(tthr_q, wd, ws);
        ssom_pkg::OFF_POS_THR:   pthr_d = merge(pthr_q, wd, ws);
        ssom_pkg::OFF_SERR_THR:  sthr_d = merge(sthr_q, wd, ws);
        ssom_pkg::OFF_ASSIGN0:   asg0_d = merge(asg0_q, wd, ws) & 32'h3fff_ffff;
        ssom_pkg::OFF_ASSIGN1:   asg1_d = merge(asg1_q, wd, ws) & 32'h3fff_ffff;
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      ssom_pkg::OFF_CTRL:      rd_val = ctrl_q;
      ssom_pkg::OFF_SOFT_WORD: rd_val = soft_q;
      ssom_pkg::OFF_ZERO_THR:  rd_val = zthr_q;
      ssom_pkg::OFF_TGT_THR:   rd_val = tthr_q;
      ssom_pkg::OFF_POS_THR:   rd_val = pthr_q;
      ssom_pkg::OFF_SERR_THR:  rd_val = sthr_q;
      ssom_pkg::OFF_ASSIGN0:   rd_val = asg0_q;
      ssom_pkg::OFF_ASSIGN1:   rd_val = asg1_q;
      ssom_pkg::OFF_FLAGS:     rd_val = {22'h000000, flags_q};
      ssom_pkg::OFF_OUTS:      rd_val = {{(32-N_CH){1'b0}}, out_q};
      default:                 rd_ok  = 1'b0;
    endcase
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_val;
      rresp_d  = rd_ok ? ssom_pkg::RESP_OKAY : ssom_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // flag derivation
  // ------------------------------------------------------------
  logic warn_cause;
  logic speed_mode;
  assign warn_cause = cond.rev_limit | cond.fwd_limit | cond.emerg_stop |
                      cond.comm_err | cond.undervolt;
  assign speed_mode = (mode == ssom_pkg::MODE_S) || (mode == ssom_pkg::MODE_SZ);

  always_comb begin
    flags_d = '0;
    flags_d.warning_flag = warn_cause;
    // alarm on the five warning causes waits one cycle behind the warning
    warn_seen_d = warn_cause;
    flags_d.alarm_flag = cond.alarm_any | (warn_cause & warn_seen_q);
    flags_d.servo_ready_flag = ctrl_q[ssom_pkg::CTRL_READY_BIT] &
                               !cond.alarm_any & !warn_cause;
    flags_d.zero_speed_flag = below(motor_speed, zthr_q);
    flags_d.target_speed_flag = (mode != ssom_pkg::MODE_PULSE) &&
                                (32'(motor_speed) >= tthr_q);
    flags_d.position_reached_flag = (mode == ssom_pkg::MODE_PULSE) &&
                                    below(position_error, pthr_q);
    flags_d.torque_limit_flag = cond.torque_lim;
    flags_d.overload_warning_flag = cond.overload;
    flags_d.brake_control_output = ctrl_q[ssom_pkg::CTRL_BRAKE_BIT];
    flags_d.speed_compare_flag = speed_mode && below(speed_error, sthr_q);
  end

  // ------------------------------------------------------------
  // channel mapping
  // ------------------------------------------------------------
  function automatic logic fn_value(input logic [7:0] fn, input ssom_pkg::ssom_flags_type f,
                                    input logic [15:0] sw);
    logic v;
    v = 1'b0;
    if (fn[7:4] == ssom_pkg::FN_SOFT0[7:4]) begin
      v = sw[fn[3:0]];
    end else begin
      case (fn)
        ssom_pkg::FN_READY: v = f.servo_ready_flag;
        ssom_pkg::FN_ZERO:  v = f.zero_speed_flag;
        ssom_pkg::FN_TGT:   v = f.target_speed_flag;
        ssom_pkg::FN_POS:   v = f.position_reached_flag;
        ssom_pkg::FN_TORQUE: v = f.torque_limit_flag;
        ssom_pkg::FN_ALARM: v = f.alarm_flag;
        ssom_pkg::FN_BRAKE: v = f.brake_control_output;
        ssom_pkg::FN_OVL:   v = f.overload_warning_flag;
        ssom_pkg::FN_WARN:  v = f.warning_flag;
        ssom_pkg::FN_SCMP:  v = f.speed_compare_flag;
        default:            v = 1'b0;
      endcase
    end
    return v;
  endfunction

  always_comb begin
    logic [59:0] fld_all;
    logic [9:0]  fld;
    logic        en;
    // both words side by side, so no channel slice ever leaves its vector
    fld_all = {asg1_q[29:0], asg0_q[29:0]};
    fld     = '0;
    en      = 1'b0;
    for (int c = 0; c < N_CH; c++) begin
      fld = fld_all[c*ssom_pkg::ASSIGN_FIELD_W +: ssom_pkg::ASSIGN_FIELD_W];
      // bit 8: active in pulse-train mode, bit 9: active in other modes
      en = (mode == ssom_pkg::MODE_PULSE) ? fld[8] : fld[9];
      out_d[c] = en & fn_value(fld[7:0], flags_q, soft_q[15:0]);
    end
  end

  assign out_channel = out_q;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= ssom_pkg::RST_CTRL;
      soft_q <= 32'h0000_0000;
      zthr_q <= ssom_pkg::RST_ZERO;
      tthr_q <= ssom_pkg::RST_TGT;
      pthr_q <= ssom_pkg::RST_POS;
      sthr_q <= ssom_pkg::RST_SERR;
      asg0_q <= ssom_pkg::RST_ASSIGN;
      asg1_q <= ssom_pkg::RST_ASSIGN;
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= 2'h0;
      flags_q     <= '0;
      warn_seen_q <= 1'b0;
      out_q       <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      soft_q <= soft_d;
      zthr_q <= zthr_d;
      tthr_q <= tthr_d;
      pthr_q <= pthr_d;
      sthr_q <= sthr_d;
      asg0_q <= asg0_d;
      asg1_q <= asg1_d;
      aw_hold_q <= aw_hold_d;
      aw_addr_q <= aw_addr_d;
      w_hold_q  <= w_hold_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      flags_q     <= flags_d;
      warn_seen_q <= warn_seen_d;
      out_q       <= out_d;
    end
  end

endmodule

// >>> dv/ssom_mapper_props.sv
// checker: port-level properties of the status output mapper
`timescale 1ns/1ps
module ssom_mapper_props #(
  parameter int SPD_W = 16,
  parameter int N_CH  = 6
) (
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic [N_CH-1:0] out_channel,
  input wire logic [7:0]      s_axi_awaddr,
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic [7:0]      s_axi_araddr,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic [1:0]      s_axi_rresp,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_quiet: assert property ($rose(aresetn) |-> out_channel == '0 && !s_axi_bvalid)
    else $error("outputs not quiet after reset");
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rdata_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ro_write_err: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && s_axi_awaddr >= ssom_pkg::OFF_FLAGS
    |=> s_axi_bvalid && s_axi_bresp == ssom_pkg::RESP_SLVERR)
    else $error("read-only or unmapped write not refused");
  a_bad_read_err: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr > ssom_pkg::OFF_OUTS
    |=> s_axi_rresp == ssom_pkg::RESP_SLVERR && s_axi_rdata == '0)
    else $error("unmapped read not refused");
endmodule

bind ssom_mapper ssom_mapper_props #(.SPD_W(SPD_W), .N_CH(N_CH)) u_props (
  .aclk, .aresetn, .out_channel, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

// >>> dv/ssom_ctrl_model.sv
// controller model: samples the drive status channels once per clock
`timescale 1ns/1ps
module ssom_ctrl_model #(
  parameter int N_CH = 6
) (
  input  wire logic            aclk,
  input  wire logic [N_CH-1:0] out_channel,
  output logic      [N_CH-1:0] seen_q
);
  // sampling adds one cycle, equal for every channel, so order survives
  always_ff @(posedge aclk) begin
    seen_q <= out_channel;
  end
endmodule

// >>> dv/tb.sv
// testbench: register, flag and channel mapping scenarios for the mapper
`timescale 1ns/1ps
module tb;
  logic                    aclk;
  logic                    aresetn;
  logic [15:0]             motor_speed, speed_error, position_error;
  ssom_pkg::ssom_cond_type cond;
  logic [5:0]              out_channel, seen_q;
  logic [7:0]              s_axi_awaddr, s_axi_araddr;
  logic [31:0]             s_axi_wdata, s_axi_rdata;
  logic [3:0]              s_axi_wstrb;
  logic [1:0]              s_axi_bresp, s_axi_rresp;
  logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                    s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                    s_axi_rvalid, s_axi_rready;
  int                      fails, n_compared;
  localparam logic [1:0]   OK = ssom_pkg::RESP_OKAY;
  localparam logic [1:0]   ER = ssom_pkg::RESP_SLVERR;

  ssom_mapper #(.SPD_W(16), .N_CH(6)) uut (
    .aclk, .aresetn, .motor_speed, .speed_error, .position_error, .cond, .out_channel,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  ssom_ctrl_model #(.N_CH(6)) u_ctrl (.aclk, .out_channel, .seen_q);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test;
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // bus and input drivers
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    // only the watchdog ends a wait for the slave
    while (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk($sformatf("bresp %h", a), 32'(er), 32'(s_axi_bresp));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    while (s_axi_arvalid || !s_axi_rvalid) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk($sformatf("rdata %h", a), e, s_axi_rdata);
    chk($sformatf("rresp %h", a), 32'(er), 32'(s_axi_rresp));
  endtask

  task automatic drv(input logic [7:0] c, input logic [15:0] sp, input logic [15:0] se,
                     input logic [15:0] pe);
    @(posedge aclk);
    {cond, motor_speed, speed_error, position_error} <= {c, sp, se, pe};
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] e [10] = '{32'h0, 32'h0, 32'ha, 32'hbb8, 32'h64, 32'ha, 32'h0, 32'h0,
                            32'h0, 32'h0};
    drv(8'h00, 16'h0064, 16'h0000, 16'h00c8);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk("out_channel", 32'h0, 32'(out_channel));
    for (int i = 0; i < 10; i++) rd(8'(4 * i), e[i], OK);
  endtask

  // row: ctrl, cond, speed, speed error, position error, expected flags
  task automatic t_flags;
    logic [79:0] r [6] = '{
      {8'h10, 8'h00, 16'h000a, 16'h0032, 16'h0064, 16'h000b},
      {8'h31, 8'h00, 16'h0bb8, 16'h000a, 16'h0000, 16'h0245},
      {8'h13, 8'h03, 16'h0bb7, 16'h000a, 16'h0000, 16'h0091},
      {8'h12, 8'h80, 16'h000b, 16'h000b, 16'h0000, 16'h0020},
      {8'h14, 8'h40, 16'h0000, 16'h0000, 16'h0000, 16'h0122},
      {8'h00, 8'h00, 16'h000b, 16'h0000, 16'h0065, 16'h0000}};
    for (int i = 0; i < 6; i++) begin
      drv(r[i][71:64], r[i][63:48], r[i][47:32], r[i][31:16]);
      wr(ssom_pkg::OFF_CTRL, 32'(r[i][79:72]), 4'hf, OK);
      rd(ssom_pkg::OFF_FLAGS, 32'(r[i][15:0]), OK);
    end
  endtask

  task automatic t_map;
    drv(8'h00, 16'h0000, 16'h0000, 16'h0000);
    wr(ssom_pkg::OFF_CTRL, 32'h31, 4'hf, OK);
    wr(ssom_pkg::OFF_SOFT_WORD, 32'h8000, 4'hf, OK);
    rd(ssom_pkg::OFF_OUTS, 32'h0, OK);
    wr(ssom_pkg::OFF_ASSIGN0, {2'b00, 10'h208, 10'h102, 10'h301}, 4'hf, OK);
    wr(ssom_pkg::OFF_ASSIGN1, {2'b00, 10'h000, 10'h33f, 10'h306}, 4'hf, OK);
    repeat (2) @(posedge aclk);
    rd(ssom_pkg::OFF_OUTS, 32'h15, OK);
    chk("out_channel", 32'h15, 32'(out_channel));
    wr(ssom_pkg::OFF_CTRL, 32'h30, 4'hf, OK);
    repeat (2) @(posedge aclk);
    rd(ssom_pkg::OFF_OUTS, 32'h13, OK);
  endtask

  task automatic t_warn;
    int n;
    wr(ssom_pkg::OFF_ASSIGN0, {2'b00, 10'h000, 10'h307, 10'h311}, 4'hf, OK);
    for (int i = 0; i < 5; i++) begin
      drv(8'h00, 16'h0064, 16'h0000, 16'h0000);
      repeat (4) @(posedge aclk);
      drv(8'h40 >> i, 16'h0064, 16'h0000, 16'h0000);
      n = 0;
      while (!seen_q[0] && n < 10) begin
        @(posedge aclk);
        n++;
      end
      chk("warning pin", 32'h1, 32'(seen_q[0]));
      chk("alarm pin early", 32'h0, 32'(seen_q[1]));
      @(posedge aclk);
      chk("alarm pin", 32'h1, 32'(seen_q[1]));
    end
  endtask

  task automatic t_soft;
    for (int n = 0; n < 16; n++) begin
      wr(ssom_pkg::OFF_ASSIGN1, {2'b00, 2'b11, 8'h30 + 8'(n), 20'h0}, 4'hf, OK);
      wr(ssom_pkg::OFF_SOFT_WORD, 32'h1 << n, 4'hf, OK);
      repeat (3) @(posedge aclk);
      chk("soft pin high", 32'h1, 32'(out_channel[5]));
      wr(ssom_pkg::OFF_SOFT_WORD, ~(32'h1 << n), 4'hf, OK);
      repeat (3) @(posedge aclk);
      chk("soft pin low", 32'h0, 32'(out_channel[5]));
    end
    rd(ssom_pkg::OFF_SOFT_WORD, 32'h0000_7fff, OK);
  endtask

  task automatic t_regs;
    wr(ssom_pkg::OFF_FLAGS, 32'h1, 4'hf, ER);
    wr(ssom_pkg::OFF_OUTS, 32'h1, 4'hf, ER);
    wr(8'h40, 32'h1, 4'hf, ER);
    rd(8'h40, 32'h0, ER);
    wr(ssom_pkg::OFF_ZERO_THR, 32'hffff_ffff, 4'h1, OK);
    rd(ssom_pkg::OFF_ZERO_THR, 32'h0000_00ff, OK);
    wr(ssom_pkg::OFF_CTRL, 32'hffff_ffff, 4'hf, OK);
    rd(ssom_pkg::OFF_CTRL, 32'h0000_0037, OK);
    wr(ssom_pkg::OFF_ASSIGN1, 32'hffff_ffff, 4'hf, OK);
    rd(ssom_pkg::OFF_ASSIGN1, 32'h3fff_ffff, OK);
  endtask

  initial begin
    {aresetn, cond, motor_speed, speed_error, position_error} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    fails = 0;
    n_compared = 0;
    t_reset();
    t_flags();
    t_map();
    t_warn();
    t_soft();
    t_regs();
    t_reset();
    finish_test();
  end

  // run needs about 500 cycles; twenty times that means a hang
  initial begin
    repeat (10000) @(posedge aclk);
    fails++;
    finish_test();
  end
endmodule
